// *** dv/link_master.sv ***
// Two-wire bus master model driving the serial clock and the open-drain data line
`timescale 1ns/1ns
`default_nettype none

module link_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_low_o
);
    int slow = 0;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic start();
        @(posedge clk_i) sda_low_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
        tick(1);
    endtask : start

    task automatic stop();
        @(posedge clk_i) sda_low_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b0;
        tick(8);
    endtask : stop

    // Data moves only in the low phase; slow stretches that phase
    task automatic bit_io(input logic v, output logic s);
        @(posedge clk_i) sda_low_o <= !v;
        tick(2 + slow);
        scl_o <= 1'b1;
        tick(4);
        s = sda_i;
        scl_o <= 1'b0;
        tick(1);
    endtask : bit_io

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask : send

    task automatic recv(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(!more, s);
    endtask : recv
endmodule : link_master
`default_nettype wire

// *** dv/serial_eeprom_bus_slave_bench.sv ***
// Self-checking bench of the two-wire EEPROM target
`timescale 1ns/1ns
`default_nettype none

module serial_eeprom_bus_slave_bench;
    import eeprom_pkg::*;
    localparam int WR_CYC = 200;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] strap = 3'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] wbo;
    logic [31:0] rdat;
    logic ack;
    logic scl;
    logic m_low;
    logic sda_oe;
    logic sda_unused;
    wire logic sda = !(m_low | sda_oe);
    logic [7:0] mem [0:2047];
    int ctr = 0;
    int errors = 0;
    int check_count = 0;
    int seed = 32'h0d8fc3e3;

    initial forever #5 clk_i = ~clk_i;

    eeprom_target #(.WR_CYCLES(WR_CYC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_unused), .sda_oe_o(sda_oe),
        .strap_bit_high_i(strap[2]), .strap_bit_mid_i(strap[1]), .strap_bit_low_i(strap[0]),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(wbo), .wb_ack_o(ack));

    link_master i_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic summarize();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            summarize();
        end
        rdat = wbo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // ****************************************
    // Reference model
    // ****************************************
    function automatic int amask(input int d);
        return (128 << d) - 1;
    endfunction : amask

    function automatic logic [7:0] devw(input int d, input int a, input logic rd);
        logic [2:0] hi;
        hi = a[10:8];
        if (d < 2) hi = strap;
        else if (d == 2) hi[2:1] = strap[2:1];
        else if (d == 3) hi[2] = strap[2];
        return {DEV_PREFIX, hi, rd};
    endfunction : devw

    task automatic expect_ack(input logic [7:0] b, input logic exp);
        logic k;
        i_master.send(b, k);
        check({31'h0, k}, {31'h0, exp});
    endtask : expect_ack

    // Repeats start and device word until acknowledged
    task automatic engage(input logic [7:0] dw, input logic busy);
        logic k;
        int tries;
        tries = 0;
        do begin
            i_master.start();
            i_master.send(dw, k);
            if (tries == 0 && busy) check({31'h0, k}, 32'h1);
            tries++;
        end while (k !== 1'b0 && tries < 40);
        if (k !== 1'b0) begin
            errors++;
            summarize();
        end
    endtask : engage

    task automatic write_page(input int d, input int a, input int n, input logic busy);
        int pm;
        logic [7:0] b;
        pm = (d < 2) ? 7 : 15;
        engage(devw(d, a, 1'b0), busy);
        expect_ack(a[7:0], 1'b0);
        a = a & amask(d);
        repeat (n) begin
            b = 8'($random(seed));
            mem[a] = b;
            expect_ack(b, 1'b0);
            a = (a & ~pm) | ((a + 1) & pm);
        end
        ctr = a;
        i_master.stop();
        wb(1'b0, STAT_OFS, 32'h0);
        check({31'h0, rdat[BUSY_BIT]}, 32'h1);
        check({31'h0, rdat[ACT_BIT]}, 32'h0);
        check(32'(rdat[ADDR_LSB +: AW]), ctr);
    endtask : write_page

    task automatic read_seq(input int d, input int n);
        logic [7:0] b;
        logic [7:0] exp_q[$];
        expect_ack(devw(d, ctr, 1'b1), 1'b0);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mem[ctr]);
            ctr = (ctr + 1) & amask(d);
        end
        for (int i = 0; i < n; i++) begin
            i_master.recv(i < n - 1, b);
            check({24'h0, b}, {24'h0, exp_q.pop_front()});
        end
        i_master.stop();
        check({31'h0, sda_oe}, 32'h0);
        check({31'h0, sda_unused}, 32'h0);
    endtask : read_seq

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int top;
        int pg;
        logic [7:0] dw;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(1'b0, 4'h8, 32'h0);
        check(rdat, 32'h0);
        wb(1'b0, CTRL_OFS, 32'h0);
        check(32'(rdat[2:0]), 32'(DENS_RST));
        for (int d = 0; d < 5; d++) begin
            strap <= 3'($random(seed));
            wb(1'b1, CTRL_OFS, d);
            wb(1'b0, CTRL_OFS, 32'h0);
            check(32'(rdat[2:0]), d);
            i_master.slow = d[0] ? 3 : 0;
            pg = (d < 2) ? 8 : 16;
            dw = devw(d, 0, 1'b0);
            i_master.start();
            expect_ack(dw ^ 8'h80, 1'b1);
            i_master.start();
            expect_ack(dw ^ 8'h08, (d < 4));
            i_master.stop();
            top = amask(d) & ~(pg - 1);
            write_page(d, top + ($random(seed) & (pg - 1)), pg + 2, 1'b0);
            write_page(d, $random(seed) & (pg - 1), pg + 2, 1'b1);
            engage(devw(d, top, 1'b0), 1'b1);
            expect_ack(top[7:0], 1'b0);
            ctr = top;
            i_master.start();
            read_seq(d, 2 * pg - 1);
            i_master.start();
            read_seq(d, 1);
        end
        summarize();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        errors++;
        summarize();
    end
endmodule : serial_eeprom_bus_slave_bench
`default_nettype wire

// *** hdl/eeprom_pkg.sv ***
// Shared constants and types of the two-wire EEPROM target
package eeprom_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int TWR_US = 5000;
    localparam int TWR_CYCLES = TWR_US * CLK_MHZ;
    localparam int TMR_W = 24;

    // ****************************************
    // Addressing
    // ****************************************
    localparam int AW = 11;
    localparam logic [3:0] DEV_PREFIX = 4'ha;
    localparam logic [AW-1:0] PAGE_LO_SMALL = 11'h007;
    localparam logic [AW-1:0] PAGE_LO_LARGE = 11'h00f;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam int DENS_LSB = 0;
    localparam int BUSY_BIT = 0;
    localparam int ACT_BIT = 1;
    localparam int ADDR_LSB = 8;

    typedef enum logic [2:0] {D1K, D2K, D4K, D8K, D16K} dens_t;
    localparam dens_t DENS_RST = D16K;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_WADR, ST_WDAT, ST_ACK, ST_RDAT, ST_RACK
    } state_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
        logic [2:0] strap;
    } link_ev_t;

    typedef struct packed {
        state_t st;
        state_t nx;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] dev;
        logic [AW-1:0] addr;
        logic oe;
        logic mack;
        logic wpend;
        logic busy;
        logic [TMR_W-1:0] tmr;
        dens_t dens;
        logic ack;
        logic [31:0] dat;
    } core_t;

endpackage : eeprom_pkg

// *** hdl/eeprom_target.sv ***
// Two-wire serial EEPROM target with array, write timer and Wishbone status port
// Operation
// R1: Every start is followed by an 8-bit device word; only a selecting word engages.
// R2: Upper four device word bits must equal the fixed family prefix.
// R3: 1K and 2K compare the next three bits with all three straps.
// R4: 4K compares two upper straps; third bit becomes page select; low strap unused.
// R5: 8K compares only the upper strap; next two bits select the page.
// R6: 16K ignores straps; page bits become most significant word address bits.
// R7: Eighth device word bit high means read, low means write.
// R8: Matching word gets zero acknowledge; mismatch gets none and device returns idle.
// R9: Byte write: device word, word address, one data byte, each acknowledged, then stop.
// R10: Stop after write starts timed write cycle; device stays silent until done.
// R11: Page holds 8 bytes on 1K/2K and 16 bytes on larger densities.
// R12: Page write sends up to seven or fifteen extra bytes, each acknowledged.
// R13: Writes increment only low three or four address bits, wrapping in page.
// R14: Polling start and device word acknowledged only after write cycle completes.
// R15: Address counter holds last accessed address plus one, kept between transfers.
// R16: Reads wrap from last byte of memory to first; writes wrap in page.
// R17: Current address read returns byte at counter; master ends with no-ack and stop.
// R18: Random read is dummy write of word address, repeated start, then read.
// R19: Sequential read continues while master acknowledges; ends on no-ack and stop.
// R20: Data falling while clock high is start, preceding every command.
// R21: Data rising while clock high is stop; after a read it returns to standby.
// R22: Data changes only while clock is low outside start and stop.
// R23: Words are eight bits; receiver acknowledges with zero in ninth clock.
// R24: Most significant bit first; data line released unless driving ack or read bit.
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none

module eeprom_target
    import eeprom_pkg::*;
#(
    parameter int WR_CYCLES = TWR_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic strap_bit_high_i,
    input wire logic strap_bit_mid_i,
    input wire logic strap_bit_low_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic dev_hit(dens_t d, logic [7:0] dv, logic [2:0] st);
        logic ok;
        ok = (dv[7:4] == DEV_PREFIX); // [R2]
        case (d)
            D1K, D2K: ok = ok & (dv[3:1] == st); // [R3]
            D4K: ok = ok & (dv[3:2] == st[2:1]); // [R4]
            D8K: ok = ok & (dv[3] == st[2]); // [R5]
            default: ok = ok; // [R6]
        endcase
        return ok;
    endfunction : dev_hit

    function automatic logic [AW-1:0] addr_mask(dens_t d);
        logic [AW-1:0] m;
        case (d)
            D1K: m = 11'h07f;
            D2K: m = 11'h0ff;
            D4K: m = 11'h1ff;
            D8K: m = 11'h3ff;
            default: m = 11'h7ff;
        endcase
        return m;
    endfunction : addr_mask

    function automatic logic [AW-1:0] page_lo(dens_t d);
        return (d == D1K || d == D2K) ? PAGE_LO_SMALL : PAGE_LO_LARGE;
    endfunction : page_lo

    // ****************************************
    // Link sampling
    // ****************************************
    link_ev_t ev;

    link_sampler u_samp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .strap_i({strap_bit_high_i, strap_bit_mid_i, strap_bit_low_i}),
        .ev_o(ev)
    );

    // ****************************************
    // Array
    // ****************************************
    core_t s_reg;
    core_t s_next;
    logic [7:0] mem [0:(1<<AW)-1];
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] mem_rd;

    assign mem_rd = mem[s_reg.addr];

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ****************************************
    // State
    // ****************************************
    logic hit;
    logic do_load;
    logic [AW-1:0] lo;
    logic [AW-1:0] am;

    assign lo = page_lo(s_reg.dens);
    assign am = addr_mask(s_reg.dens);
    assign hit = dev_hit(s_reg.dens, s_reg.sh, ev.strap);

    always_comb begin
        s_next = s_reg;
        mem_we = 1'b0;
        mem_wa = s_reg.addr;
        mem_wd = s_reg.sh;
        do_load = 1'b0;

        // Register port: one wait state, ack drops after one cycle
        s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        if (s_next.ack) begin
            if (wb_adr_i == CTRL_OFS) begin
                s_next.dat = 32'h0;
                s_next.dat[DENS_LSB +: 3] = s_reg.dens;
            end else if (wb_adr_i == STAT_OFS) begin
                s_next.dat = 32'h0;
                s_next.dat[BUSY_BIT] = s_reg.busy;
                s_next.dat[ACT_BIT] = (s_reg.st != ST_IDLE);
                s_next.dat[ADDR_LSB +: AW] = s_reg.addr;
            end else begin
                s_next.dat = 32'h0;
            end
        end

        // A write lands at the edge at which the master samples ack
        if (wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack) begin
            if (wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
                s_next.dens = dens_t'(wb_dat_i[DENS_LSB +: 3]);
            end
        end

        // Self-timed write cycle
        if (s_reg.busy) begin
            if (s_reg.tmr == '0) begin
                s_next.busy = 1'b0;
            end else begin
                s_next.tmr = s_reg.tmr - 1'b1;
            end
        end

        // Serial link
        if (ev.stop) begin
            s_next.st = ST_IDLE; // [R21]
            s_next.oe = 1'b0;
            if (s_reg.wpend) begin
                s_next.wpend = 1'b0;
                s_next.busy = 1'b1; // [R10]
                s_next.tmr = TMR_W'(WR_CYCLES - 1);
            end
        end else if (ev.start) begin
            s_next.oe = 1'b0;
            // Inputs are ignored while the write cycle runs, so polls see no ack
            s_next.st = s_reg.busy ? ST_IDLE : ST_DEV; // [R10] [R14] [R20]
            s_next.cnt = 4'h0;
        end else if (!s_reg.busy) begin
            case (s_reg.st)
                ST_DEV, ST_WADR, ST_WDAT: begin
                    if (ev.scl_rise && s_reg.cnt != 4'h8) begin
                        s_next.sh = {s_reg.sh[6:0], ev.sda}; // [R24] [R22]
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end else if (ev.scl_fall && s_reg.cnt == 4'h8) begin
                        s_next.oe = 1'b1; // [R23]
                        s_next.st = ST_ACK;
                        if (s_reg.st == ST_DEV) begin
                            s_next.dev = s_reg.sh; // [R1]
                            s_next.nx = s_reg.sh[0] ? ST_RDAT : ST_WADR; // [R7]
                            if (!hit) begin
                                s_next.oe = 1'b0; // [R8]
                                s_next.st = ST_IDLE;
                            end
                        end else if (s_reg.st == ST_WADR) begin
                            // Page bits of the device word are the upper address bits
                            s_next.addr = {s_reg.dev[3:1], s_reg.sh} & am; // [R6] [R18]
                            s_next.nx = ST_WDAT;
                        end else begin
                            mem_we = 1'b1; // [R9] [R12]
                            s_next.wpend = 1'b1;
                            s_next.addr = (s_reg.addr & ~lo) | ((s_reg.addr + 1'b1) & lo); // [R13] [R11] [R16]
                            s_next.nx = ST_WDAT;
                        end
                    end
                end
                ST_ACK: begin
                    if (ev.scl_fall) begin
                        s_next.oe = 1'b0; // [R24]
                        s_next.cnt = 4'h0;
                        s_next.st = s_reg.nx;
                        do_load = (s_reg.nx == ST_RDAT); // [R17]
                    end
                end
                ST_RDAT: begin
                    if (ev.scl_fall) begin
                        if (s_reg.cnt == 4'h7) begin
                            s_next.oe = 1'b0;
                            s_next.st = ST_RACK;
                        end else begin
                            s_next.cnt = s_reg.cnt + 4'h1;
                            s_next.sh = {s_reg.sh[6:0], 1'b0};
                            s_next.oe = ~s_reg.sh[6]; // [R24]
                        end
                    end
                end
                ST_RACK: begin
                    if (ev.scl_rise) begin
                        s_next.mack = ~ev.sda;
                    end else if (ev.scl_fall) begin
                        if (s_reg.mack) begin
                            do_load = 1'b1; // [R19]
                        end else begin
                            s_next.st = ST_IDLE;
                        end
                    end
                end
                default: begin
                    s_next.oe = 1'b0;
                end
            endcase
        end

        if (do_load) begin
            s_next.st = ST_RDAT;
            s_next.cnt = 4'h0;
            s_next.sh = mem_rd;
            s_next.oe = ~mem_rd[7];
            s_next.addr = (s_reg.addr + 1'b1) & am; // [R15] [R16]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '{st: ST_IDLE, nx: ST_IDLE, dens: DENS_RST, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sda_o = 1'b0;
    assign sda_oe_o = s_reg.oe;
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic dev_end;
    logic [AW-1:0] page_hi;
    logic [AW-1:0] rd_next;

    assign dev_end = (s_reg.st == ST_DEV) && ev.scl_fall && (s_reg.cnt == 4'h8) && !ev.start && !ev.stop;
    assign page_hi = s_reg.addr & ~lo;
    assign rd_next = (s_reg.addr + 1'b1) & am;

    prefix_match_a: assert property (dev_end && hit |-> s_reg.sh[7:4] == DEV_PREFIX) // [R2]
        else $error("ack given without family prefix");
    strap_small_a: assert property (dev_end && hit && s_reg.dens inside {D1K, D2K}
        |-> s_reg.sh[3:1] == ev.strap) // [R3]
        else $error("small density ack with strap mismatch");
    strap_mid_a: assert property (dev_end && hit && s_reg.dens == D4K |-> s_reg.sh[3:2] == ev.strap[2:1]) // [R4]
        else $error("4K ack with strap mismatch");
    strap_high_a: assert property (dev_end && hit && s_reg.dens == D8K |-> s_reg.sh[3] == ev.strap[2]) // [R5]
        else $error("8K ack with strap mismatch");
    dev_ack_a: assert property (dev_end |=> (s_reg.oe == $past(hit)) ##1 1'b1) // [R8]
        else $error("device word acknowledge wrong");
    nack_idle_a: assert property (dev_end && !hit |=> s_reg.st == ST_IDLE [*2]) // [R8]
        else $error("mismatch did not return to idle");
    busy_silent_a: assert property (s_reg.busy && !$rose(s_reg.busy) |-> !s_reg.oe) // [R10]
        else $error("line driven during write cycle");
    wr_start_a: assert property (ev.stop && s_reg.wpend |=> s_reg.busy && s_reg.tmr == TMR_W'(WR_CYCLES - 1)) // [R10]
        else $error("write cycle not started on stop");
    page_keep_a: assert property (mem_we |=> page_hi == $past(page_hi)) // [R13]
        else $error("write increment left the page");
    read_inc_a: assert property (do_load |=> s_reg.addr == $past(rd_next) && s_reg.st == ST_RDAT) // [R16]
        else $error("read increment wrong");
    stop_idle_a: assert property (ev.stop |=> s_reg.st == ST_IDLE && !s_reg.oe) // [R21]
        else $error("stop did not release the link");

    // Link output discipline, then array write, write timer and address counter checks
    oe_on_fall_a: assert property (!ev.scl_fall && !ev.start && !ev.stop |=> s_reg.oe == $past(s_reg.oe)) // [R22]
        else $error("data line changed outside clock low");
    idle_quiet_a: assert property (s_reg.st == ST_IDLE |-> !s_reg.oe) // [R24]
        else $error("line driven while idle");
    rack_release_a: assert property (s_reg.st == ST_RACK |-> !s_reg.oe) // [R23]
        else $error("line driven in master acknowledge slot");
    read_bit_a: assert property (s_reg.st == ST_RDAT |-> s_reg.oe == !s_reg.sh[7]) // [R24]
        else $error("read bit not taken from the top of the shifter");
    load_byte_a: assert property (do_load // [R17]
        |=> s_reg.sh == $past(mem_rd) && s_reg.cnt == 4'h0)
        else $error("read byte not loaded from the counter address");
    nack_end_a: assert property (s_reg.st == ST_RACK && ev.scl_fall && !s_reg.mack // [R19]
        && !ev.start && !ev.stop |=> s_reg.st == ST_IDLE)
        else $error("read went on after master withheld acknowledge");
    write_slot_a: assert property (mem_we |-> s_reg.st == ST_WDAT && s_reg.cnt == 4'h8) // [R9]
        else $error("array written outside a data byte");
    page_wrap_a: assert property (mem_we && (s_reg.addr & lo) == lo |=> (s_reg.addr & $past(lo)) == '0) // [R11]
        else $error("page write did not wrap at the page size");
    busy_end_a: assert property ($fell(s_reg.busy) |-> $past(s_reg.tmr) == '0) // [R10]
        else $error("write cycle ended before its time");
    poll_idle_a: assert property (s_reg.busy && ev.start |=> s_reg.st == ST_IDLE && !s_reg.oe) // [R14]
        else $error("device answered a poll during the write cycle");
    addr_keep_a: assert property (s_reg.st == ST_IDLE |=> s_reg.addr == $past(s_reg.addr)) // [R15]
        else $error("address counter moved between transfers");

    page_write_c: cover property (mem_we ##[1:1000] mem_we ##[1:1000] $rose(s_reg.busy));
    seq_read_c: cover property (do_load ##[1:1000] do_load);
    poll_nack_c: cover property (s_reg.busy && ev.start);
    poll_ack_c: cover property ($fell(s_reg.busy) ##[1:1000] (dev_end && hit));
    page_wrap_c: cover property (mem_we && (s_reg.addr & lo) == lo);

endmodule : eeprom_target

`default_nettype wire

// *** hdl/link_sampler.sv ***
// Pin synchroniser and start/stop/edge detector of the serial link
`timescale 1ns/1ns
`default_nettype none

module link_sampler
    import eeprom_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] strap_i,
    output link_ev_t ev_o
);

    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] sync;
        logic scl_last;
        logic sda_last;
    } samp_t;

    samp_t s_reg;
    samp_t s_next;

    // ****************************************
    // Two-stage sampling, then edge history
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.meta = {scl_i, sda_i, strap_i};
        s_next.sync = s_reg.meta;
        s_next.scl_last = s_reg.sync[4];
        s_next.sda_last = s_reg.sync[3];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '{meta: 5'h1f, sync: 5'h1f, scl_last: 1'b1, sda_last: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Events
    // ****************************************
    always_comb begin
        ev_o.scl_rise = s_reg.sync[4] & ~s_reg.scl_last;
        ev_o.scl_fall = ~s_reg.sync[4] & s_reg.scl_last;
        ev_o.start = s_reg.sync[4] & s_reg.scl_last & s_reg.sda_last & ~s_reg.sync[3]; // [R20]
        ev_o.stop = s_reg.sync[4] & s_reg.scl_last & ~s_reg.sda_last & s_reg.sync[3]; // [R21]
        ev_o.sda = s_reg.sync[3];
        ev_o.strap = s_reg.sync[2:0];
    end

endmodule : link_sampler

`default_nettype wire
